/* File: src/bridge_cmd_pkg.sv */
// Constants and carrier types for the bridge command and status registers
`default_nettype none
package bridge_cmd_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] CMD_STATUS_OFF = 8'h04;

	// ----------------------------------------
	// AXI response codes
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ----------------------------------------
	// Command field positions
	// ----------------------------------------
	localparam int CMD_IO_EN    = 0;
	localparam int CMD_MEM_EN   = 1;
	localparam int CMD_MASTER   = 2;
	localparam int CMD_PALETTE  = 5;
	localparam int CMD_PAR_RESP = 6;
	localparam int CMD_SERR_EN  = 8;
	localparam int CMD_FB2B_EN  = 9;
	localparam logic [15:0] CMD_WR_MASK = 16'h0367;
	localparam logic [15:0] CMD_RESET   = 16'h0000;

	// ----------------------------------------
	// Status field positions (within upper half)
	// ----------------------------------------
	localparam int ST_DATA_PAR  = 8;
	localparam int ST_SIG_TABT  = 11;
	localparam int ST_RCV_TABT  = 12;
	localparam int ST_RCV_MABT  = 13;
	localparam int ST_SIG_SERR  = 14;
	localparam int ST_DET_PAR   = 15;
	localparam logic [15:0] ST_W1C_MASK = 16'hF900;
	localparam logic [15:0] ST_FIXED    = 16'h02B0;
	localparam logic [15:0] ST_RESET    = 16'h0000;

	// ----------------------------------------
	// Palette snoop addresses (low ten bits)
	// ----------------------------------------
	localparam logic [9:0] PAL_MASK_ADDR  = 10'h3C6;
	localparam logic [9:0] PAL_WADDR_ADDR = 10'h3C8;
	localparam logic [9:0] PAL_DATA_ADDR  = 10'h3C9;

	// Decoded primary-side access offered for a claim decision
	typedef struct packed {
		logic        valid;
		logic        isIo;
		logic        isMem;
		logic        isWrite;
		logic        winHit;
		logic [15:0] addr;
	} decode_req_s;

	// Whole block state
	typedef struct packed {
		logic              awRdy;
		logic              wRdy;
		logic              arRdy;
		logic              awHeld;
		logic              wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [DATA_W-1:0] wData;
		logic [3:0]        wStrb;
		logic              bValid;
		logic [1:0]        bResp;
		logic              rValid;
		logic [1:0]        rResp;
		logic [DATA_W-1:0] rData;
		logic [15:0]       cmd;
		logic [15:0]       sticky;
		logic              claim;
		logic              parReport;
		logic              serrOen;
	} state_s;

endpackage
`default_nettype wire

/* File: src/bridge_command_status_regs.sv */
// Primary-side command and status register pair with AXI4-Lite access
//
// Notes on behaviour
// - I/O window claims only while command bit 0 set
// - Memory claims only while command bit 1 set
// - Bit 2 gates primary mastering, secondary response
// - Special cycle bit reads zero, read-only
// - Write-and-invalidate bit reads zero, read-only
// - Bit 5 claims palette writes 3C6/3C8/3C9
// - Bit 6 enables normal parity error actions
// - Stepping bit reads zero, read-only
// - System-error driver enabled only by bit 8
// - Fast back-to-back generation gated by bit 9
// - Command bits 15:10 read zero
// - Capability list bit reads one
// - 66MHz capable bit reads one
// - Fast back-to-back capable bit reads one
// - Parity line plus bit 6 sets bit 24
// - Select timing field reads medium, 01
// - Signalled target abort sets bit 27
// - Received target abort sets bit 28
// - Received master abort sets bit 29
// - Asserting system error sets bit 30
// - Any primary parity error sets bit 31
//
// Implementation choice: the AXI4-Lite interface to the registers.
`default_nettype none
module bridge_command_status_regs (
	input  wire logic                               clk,
	input  wire logic                               rst_n,
	// AXI4-Lite slave
	input  wire logic [bridge_cmd_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [bridge_cmd_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	output logic [1:0]                              s_axi_bresp,
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [bridge_cmd_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	output logic [bridge_cmd_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	// Primary decode and claim
	input  wire bridge_cmd_pkg::decode_req_s        decodeReq,
	output logic                                    primaryClaim,
	// Bridge events
	input  wire logic                               parityErrDetected,
	input  wire logic                               primaryParityErrorLine_n,
	input  wire logic                               serrRequest,
	input  wire logic                               targetAbortSignaled,
	input  wire logic                               targetAbortReceived,
	input  wire logic                               masterAbortReceived,
	// Controls to the datapath
	output logic                                    parityReport,
	output logic                                    primaryMasterEn,
	output logic                                    secondaryRespEn,
	output logic                                    fastB2bEn,
	output logic                                    parityRespEn,
	// Open-drain system error pin
	output logic                                    primarySystemErrorOut,
	output logic                                    primarySystemErrorOe_n
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	bridge_cmd_pkg::state_s st;
	bridge_cmd_pkg::state_s nxt_st;

	logic [9:0]  palAddr;
	logic        palHit;
	logic        awFire;
	logic        wFire;
	logic        arFire;
	logic        wrHit;
	logic        rdHit;
	logic [15:0] cmdBe;
	logic [15:0] stBe;
	logic [15:0] stSet;
	logic [15:0] stClr;
	logic        serrNow;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		nxt_st = st;
		awFire = s_axi_awvalid && st.awRdy;
		wFire  = s_axi_wvalid && st.wRdy;
		arFire = s_axi_arvalid && st.arRdy;
		wrHit  = st.awAddr[bridge_cmd_pkg::ADDR_W-1:2]
			== bridge_cmd_pkg::CMD_STATUS_OFF[bridge_cmd_pkg::ADDR_W-1:2];
		rdHit  = s_axi_araddr[bridge_cmd_pkg::ADDR_W-1:2]
			== bridge_cmd_pkg::CMD_STATUS_OFF[bridge_cmd_pkg::ADDR_W-1:2];
		cmdBe  = {{8{st.wStrb[1]}}, {8{st.wStrb[0]}}};
		stBe   = {{8{st.wStrb[3]}}, {8{st.wStrb[2]}}};
		stSet  = 16'h0000;
		stClr  = 16'h0000;

		// Capture write address and data in either order
		if (awFire) begin
			nxt_st.awHeld = 1'b1;
			nxt_st.awAddr = s_axi_awaddr;
		end
		if (wFire) begin
			nxt_st.wHeld = 1'b1;
			nxt_st.wData = s_axi_wdata;
			nxt_st.wStrb = s_axi_wstrb;
		end

		// Commit once both halves are held
		if (st.awHeld && st.wHeld && !st.bValid) begin
			nxt_st.awHeld = 1'b0;
			nxt_st.wHeld  = 1'b0;
			nxt_st.bValid = 1'b1;
			if (wrHit) begin
				nxt_st.bResp = bridge_cmd_pkg::RESP_OKAY;
				// Only writable command bits are stored, rest read zero
				nxt_st.cmd = (st.cmd & ~(cmdBe & bridge_cmd_pkg::CMD_WR_MASK))
					| (st.wData[15:0] & cmdBe & bridge_cmd_pkg::CMD_WR_MASK);
				stClr = st.wData[31:16] & stBe & bridge_cmd_pkg::ST_W1C_MASK;
			end else begin
				nxt_st.bResp = bridge_cmd_pkg::RESP_DECERR;
			end
		end
		if (st.bValid && s_axi_bready) begin
			nxt_st.bValid = 1'b0;
		end

		// Read channel
		if (arFire) begin
			nxt_st.rValid = 1'b1;
			if (rdHit) begin
				nxt_st.rResp = bridge_cmd_pkg::RESP_OKAY;
				// Capability bits are constants ORed onto the sticky flags
				nxt_st.rData = {st.sticky | bridge_cmd_pkg::ST_FIXED, st.cmd};
			end else begin
				nxt_st.rResp = bridge_cmd_pkg::RESP_DECERR;
				nxt_st.rData = 32'h0000_0000;
			end
		end else if (st.rValid && s_axi_rready) begin
			nxt_st.rValid = 1'b0;
		end

		// Ready only while nothing is pending, so a channel never overruns
		nxt_st.awRdy = !nxt_st.awHeld && !nxt_st.bValid;
		nxt_st.wRdy  = !nxt_st.wHeld && !nxt_st.bValid;
		nxt_st.arRdy = !nxt_st.rValid;

		// Palette snoop ignores upper alias bits
		palAddr = decodeReq.addr[9:0];
		palHit  = (palAddr == bridge_cmd_pkg::PAL_MASK_ADDR)
			|| (palAddr == bridge_cmd_pkg::PAL_WADDR_ADDR)
			|| (palAddr == bridge_cmd_pkg::PAL_DATA_ADDR);

		// Claim decision, one cycle after the offered access
		nxt_st.claim = decodeReq.valid && (
			(decodeReq.isIo && decodeReq.winHit && st.cmd[bridge_cmd_pkg::CMD_IO_EN])
			|| (decodeReq.isMem && decodeReq.winHit
				&& st.cmd[bridge_cmd_pkg::CMD_MEM_EN])
			|| (decodeReq.isIo && decodeReq.isWrite && palHit
				&& st.cmd[bridge_cmd_pkg::CMD_PALETTE]));

		// Normal parity action requested only when enabled
		nxt_st.parReport = parityErrDetected && st.cmd[bridge_cmd_pkg::CMD_PAR_RESP];

		// System error pin drives low only when enabled
		serrNow = serrRequest && st.cmd[bridge_cmd_pkg::CMD_SERR_EN];
		nxt_st.serrOen = !serrNow;

		// Sticky event flags
		stSet[bridge_cmd_pkg::ST_DATA_PAR] = !primaryParityErrorLine_n
			&& st.cmd[bridge_cmd_pkg::CMD_PAR_RESP];
		stSet[bridge_cmd_pkg::ST_SIG_TABT] = targetAbortSignaled;
		stSet[bridge_cmd_pkg::ST_RCV_TABT] = targetAbortReceived;
		stSet[bridge_cmd_pkg::ST_RCV_MABT] = masterAbortReceived;
		stSet[bridge_cmd_pkg::ST_SIG_SERR] = serrNow;
		stSet[bridge_cmd_pkg::ST_DET_PAR]  = parityErrDetected;

		// Set wins over a clear in the same cycle
		nxt_st.sticky = (st.sticky & ~stClr) | stSet;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st        <= '0;
			st.cmd    <= bridge_cmd_pkg::CMD_RESET;
			st.sticky <= bridge_cmd_pkg::ST_RESET;
			st.serrOen <= 1'b1;
		end else begin
			st <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs, all taken from flip-flops or tied to a constant
	// ----------------------------------------
	assign s_axi_awready = st.awRdy;
	assign s_axi_wready  = st.wRdy;
	assign s_axi_arready = st.arRdy;
	assign s_axi_bvalid  = st.bValid;
	assign s_axi_bresp   = st.bResp;
	assign s_axi_rvalid  = st.rValid;
	assign s_axi_rresp   = st.rResp;
	assign s_axi_rdata   = st.rData;

	assign primaryClaim    = st.claim;
	assign parityReport    = st.parReport;
	assign parityRespEn    = st.cmd[bridge_cmd_pkg::CMD_PAR_RESP];
	// One bit gates both directions of forwarding
	assign primaryMasterEn = st.cmd[bridge_cmd_pkg::CMD_MASTER];
	assign secondaryRespEn = st.cmd[bridge_cmd_pkg::CMD_MASTER];
	assign fastB2bEn       = st.cmd[bridge_cmd_pkg::CMD_FB2B_EN];

	// Open drain: value is always low, the enable does the signalling
	assign primarySystemErrorOut  = 1'b0;
	assign primarySystemErrorOe_n = st.serrOen;

endmodule
`default_nettype wire

/* File: src/unused_placeholder_none.sv */
// Intentionally empty design unit list
`default_nettype none
`default_nettype wire

/* File: verification/bridge_cmd_properties.sv */
// Port checker for the bridge command and status registers
`default_nettype none
module bridge_cmd_checker (
	input wire logic                        clk,
	input wire logic                        rst_n,
	input wire logic [31:0]                 s_axi_rdata,
	input wire logic [1:0]                  s_axi_rresp,
	input wire logic                        s_axi_rvalid,
	input wire bridge_cmd_pkg::decode_req_s decodeReq,
	input wire logic                        primaryClaim,
	input wire logic                        parityErrDetected,
	input wire logic                        parityReport,
	input wire logic                        parityRespEn,
	input wire logic                        serrRequest,
	input wire logic                        primarySystemErrorOe_n,
	input wire logic                        primaryMasterEn,
	input wire logic                        secondaryRespEn
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// A read answer that carries register data
	sequence rdOk;
		s_axi_rvalid && s_axi_rresp == 2'h0;
	endsequence
	// A parity error seen while normal parity actions are enabled
	sequence parOn;
		parityErrDetected && parityRespEn;
	endsequence
	a_cap_bits: assert property (rdOk |-> s_axi_rdata[23:20] == 4'hB)
		else $error("capability bits wrong");
	a_sel_timing: assert property (rdOk |-> s_axi_rdata[26:25] == 2'h1)
		else $error("select timing field wrong");
	a_ro_zero: assert property (rdOk |->
		{s_axi_rdata[15:10], s_axi_rdata[7], s_axi_rdata[4:3]} == 9'h0)
		else $error("read-only command bits not zero");
	a_no_claim: assert property (!decodeReq.valid |=> !primaryClaim)
		else $error("claim without an offer");
	a_master_pair: assert property (primaryMasterEn == secondaryRespEn)
		else $error("master gates disagree");
	a_par_act: assert property (parOn |=> parityReport)
		else $error("parity action missing");
	a_par_gate: assert property (!parityRespEn |=> !parityReport)
		else $error("parity action while disabled");
	a_serr_gate: assert property (!serrRequest |=> primarySystemErrorOe_n)
		else $error("error pin driven without request");
endmodule
bind bridge_command_status_regs bridge_cmd_checker u_chk (.*);
`default_nettype wire

/* File: verification/primary_bus_model.sv */
// Primary bus agent: offers decodes, pulses events, resolves the error pin
`default_nettype none
module primary_bus_model (
	input  wire logic                       clk,
	input  wire logic                       serrOut,
	input  wire logic                       serrOe_n,
	output var bridge_cmd_pkg::decode_req_s req,
	output var logic [4:0]                  ev,
	output var logic                        serrWire
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pull-up keeps the pin high whenever nobody drives it
	assign serrWire = serrOe_n ? 1'b1 : serrOut;
	initial req = '0;
	initial ev = '0;
	// One-cycle offer, then idle again
	task offer(input logic [20:0] r);
		@(posedge clk);
		req <= r;
		@(posedge clk);
		req <= '0;
	endtask
	// One-cycle event pulse
	task pulse(input logic [4:0] e);
		@(posedge clk);
		ev <= e;
		@(posedge clk);
		ev <= '0;
	endtask
endmodule
`default_nettype wire

/* File: verification/bridge_command_status_regs_tb.sv */
// Self-checking bench for the bridge command and status registers
`default_nettype none
module bridge_command_status_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] FIX = 32'h02B00000;
	logic clk = 1'b0, rst_n = 1'b0, serrRequest = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic primaryClaim, parityReport, primaryMasterEn, secondaryRespEn, fastB2bEn;
	logic parityRespEn, primarySystemErrorOut, primarySystemErrorOe_n, serrWire;
	logic parityErrDetected, primaryParityErrorLine_n, targetAbortSignaled;
	logic targetAbortReceived, masterAbortReceived;
	logic [4:0] ev;
	bridge_cmd_pkg::decode_req_s decodeReq;
	int err_count = 0;
	int check_count = 0;
	// Event bits; the parity line idles high
	assign {parityErrDetected, primaryParityErrorLine_n, targetAbortSignaled,
		targetAbortReceived, masterAbortReceived} = ev ^ 5'h08;
	bridge_command_status_regs u_dut (.*);
	primary_bus_model u_far (.clk(clk), .serrOut(primarySystemErrorOut),
		.serrOe_n(primarySystemErrorOe_n), .req(decodeReq), .ev(ev), .serrWire(serrWire));
	// Clock
	always #12.5 clk = ~clk;
	task end_sim;
		if (err_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task chk(input logic [33:0] g, input logic [33:0] x);
		check_count++;
		if (g !== x) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	// A wait that ran out ends the run
	task tmo(input int n);
		if (n >= 50) begin
			err_count++;
			$display("[FAIL] %0t bus timeout", $time);
			end_sim;
		end
	endtask
	// Address and data offered together, each released when taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		tmo(n);
		chk(34'(s_axi_bresp), 34'(e));
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		tmo(n);
		chk({s_axi_rresp, s_axi_rdata}, {e, x});
	endtask
	// Claim is looked at in the cycle after the offer
	task cl(input logic [20:0] r, input logic e);
		u_far.offer(r);
		@(posedge clk);
		chk(34'(primaryClaim), 34'(e));
	endtask
	task pu(input logic [4:0] e);
		u_far.pulse(e);
		@(posedge clk);
	endtask
	// Reset values, unmapped places refused
	task t_reset;
		rd(8'h04, FIX, 2'h0);
		rd(8'h08, 32'h0, 2'h3);
	endtask
	// All ones into the command half: only writable bits stick
	task t_cmd;
		wr(8'h04, 32'h0000FFFF, 2'h0);
		rd(8'h04, FIX | 32'h0367, 2'h0);
		chk(34'({primaryMasterEn, secondaryRespEn, fastB2bEn, parityRespEn}), 34'hF);
		wr(8'h10, 32'h0, 2'h3);
		rd(8'h04, FIX | 32'h0367, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		chk(34'({primaryMasterEn, secondaryRespEn, fastB2bEn, parityRespEn}), 34'h0);
	endtask
	// Offers: {valid, io, mem, write, window} then address
	task t_claim;
		wr(8'h04, 32'h1, 2'h0);
		cl({5'h19, 16'h0}, 1'b1);
		cl({5'h15, 16'h0}, 1'b0);
		wr(8'h04, 32'h2, 2'h0);
		cl({5'h15, 16'h0}, 1'b1);
		cl({5'h19, 16'h0}, 1'b0);
		wr(8'h04, 32'h20, 2'h0);
		cl({5'h1A, 16'hFFC6}, 1'b1);
		cl({5'h1A, 16'h03C8}, 1'b1);
		cl({5'h1A, 16'h7BC9}, 1'b1);
		cl({5'h1A, 16'h03C7}, 1'b0);
		cl({5'h18, 16'h03C6}, 1'b0);
		wr(8'h04, 32'h0, 2'h0);
		cl({5'h1A, 16'h03C6}, 1'b0);
	endtask
	// Parity events with the response bit off, then on
	task t_parity;
		pu(5'h10);
		chk(34'(parityReport), 34'h0);
		pu(5'h08);
		rd(8'h04, FIX | 32'h80000000, 2'h0);
		wr(8'h04, 32'h40, 2'h0);
		pu(5'h10);
		chk(34'(parityReport), 34'h1);
		pu(5'h08);
		rd(8'h04, FIX | 32'h81000040, 2'h0);
		wr(8'h04, 32'h01000040, 2'h0);
		rd(8'h04, FIX | 32'h80000040, 2'h0);
		wr(8'h04, 32'h80000000, 2'h0);
		rd(8'h04, FIX, 2'h0);
	endtask
	// Abort events, then partial clear
	task t_abort;
		pu(5'h07);
		rd(8'h04, FIX | 32'h38000000, 2'h0);
		wr(8'h04, 32'h10000000, 2'h0);
		rd(8'h04, FIX | 32'h28000000, 2'h0);
		wr(8'h04, 32'h28000000, 2'h0);
	endtask
	// Error request held while the driver is off, then on
	task t_serr;
		@(posedge clk);
		serrRequest <= 1'b1;
		repeat (2) @(posedge clk);
		chk(34'({primarySystemErrorOe_n, serrWire}), 34'h3);
		rd(8'h04, FIX, 2'h0);
		wr(8'h04, 32'h100, 2'h0);
		// The enable lands at the commit edge, the driver follows one edge later
		@(posedge clk);
		chk(34'({primarySystemErrorOe_n, serrWire}), 34'h0);
		rd(8'h04, FIX | 32'h40000100, 2'h0);
		serrRequest <= 1'b0;
		repeat (2) @(posedge clk);
		wr(8'h04, 32'h40000000, 2'h0);
		rd(8'h04, FIX, 2'h0);
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_cmd;
		t_claim;
		t_parity;
		t_abort;
		t_serr;
		end_sim;
	end
endmodule
`default_nettype wire
